// ---- retimer_power_state_control.sv ----
/*
 Power-state and lane-enable control of a video link retimer, with an Avalon-MM
 register slave, pin synchronisers, input clock detection and strap decoding.
 Assumes a 200 MHz CLK and that all pins are asynchronous to it.
*/
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
// Contract
// - Power enable low: everything shut down (RX termination is kept on)
// - Power enable rise resets all settings
// - Software power-down bit forces power-down
// - Hot-plug low: power-down, port still active
// - No valid input clock: standby (in redriver mode only with signal detect enabled)
// - Standby: data lanes off, clock/DDC/ARC on
// - Power-down: termination on, outputs off
// - Normal runs as redriver or retimer
// - CDR and outputs follow signal detector
// - Source hot-plug mirrors sink hot-plug
// - Control port off only when unpowered
// - Input lane swap option
// - Configure by registers or straps
// - Straps decode low, mid, high
// - Equalizer adaptive by default, strap fixes
// - Straps choose pre-emphasis and termination
// - Status bits 7 and 6, reset zero
module retimer_power_state_control (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic POWER_ENABLE,
    input wire logic SINK_HOTPLUG_IN,
    input wire logic SIGNAL_DETECT_ENABLE,
    input wire logic INPUT_CLOCK_LANE,
    input wire logic [2:0] STRAP_I,
    output logic [2:0] STRAP_O,
    output logic [2:0] STRAP_OE,
    output logic SOURCE_HOTPLUG_OUT,
    output logic [2:0] LINK_DATA_INPUTS_ENABLE,
    output logic INPUT_CLOCK_ENABLE,
    output logic RX_TERMINATION_ON,
    output logic LINK_DATA_OUTPUTS_ENABLE,
    output logic CDR_ENABLE,
    output logic DDC_ENABLE,
    output logic ARC_ENABLE,
    output logic CONTROL_SERIAL_PORT_ENABLE,
    output logic RETIMER_MODE,
    output logic LANE_SWAP,
    output logic EQ_ADAPTIVE,
    output logic [1:0] EQ_FIXED_LEVEL,
    output logic [1:0] PREEMPHASIS_LEVEL,
    output logic [1:0] TX_TERMINATION_SEL,
    output logic POWER_DOWN_FLAG,
    output logic STANDBY_FLAG,
    output logic CONFIG_RESET
);
    logic [2:0] pin_async;
    logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [2:0] pin_level_reg;
    logic power_en, sink_hpd, sig_det_en;
    logic power_en_prev_reg;
    logic power_en_rise;
    logic restart;
    logic clock_valid;
    logic [5:0] strap_level;
    logic strap_done;
    logic [7:0] control_reg;
    logic [8:0] eq_config_reg;
    retimer_power_pkg::power_state_t state_reg, state_next;
    logic sel_control, sel_eq_config, sel_status, sel_strap;
    logic word_aligned;
    logic read_take, write_take;
    logic [31:0] read_value;
    logic [1:0] eq_strap, pre_strap, term_strap;
    logic redriver;

    assign pin_async[retimer_power_pkg::PIN_POWER_ENABLE] = POWER_ENABLE;
    assign pin_async[retimer_power_pkg::PIN_SINK_HOTPLUG] = SINK_HOTPLUG_IN;
    assign pin_async[retimer_power_pkg::PIN_SIGNAL_DETECT_EN] = SIGNAL_DETECT_ENABLE;

    // Three-stage synchroniser per pin; level moves once stages two and three agree
    for (genvar i = 0; i < retimer_power_pkg::NUM_PINS; i++) begin : g_pin_sync
        always_ff @(posedge CLK) begin
            if (RESET) begin
                pin_s1_reg[i] <= 1'b0;
                pin_s2_reg[i] <= 1'b0;
                pin_s3_reg[i] <= 1'b0;
                pin_level_reg[i] <= 1'b0;
            end else begin
                pin_s1_reg[i] <= pin_async[i];
                pin_s2_reg[i] <= pin_s1_reg[i];
                pin_s3_reg[i] <= pin_s2_reg[i];
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_level_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    assign power_en = pin_level_reg[retimer_power_pkg::PIN_POWER_ENABLE];
    assign sink_hpd = pin_level_reg[retimer_power_pkg::PIN_SINK_HOTPLUG];
    assign sig_det_en = pin_level_reg[retimer_power_pkg::PIN_SIGNAL_DETECT_EN];

    // Power enable rising edge acts as a device reset
    assign power_en_rise = power_en && !power_en_prev_reg;
    assign restart = RESET || power_en_rise;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            power_en_prev_reg <= 1'b0;
            CONFIG_RESET <= 1'b0;
        end else begin
            power_en_prev_reg <= power_en;
            CONFIG_RESET <= power_en_rise;
        end
    end

    // Valid clock detection on the input clock lane
    clock_presence_detector u_clock_detect (
        .clk(CLK),
        .reset(restart),
        .lane_in(INPUT_CLOCK_LANE),
        .valid(clock_valid)
    );

    // Strap probing, rerun after each device reset
    strap_tri_level_decoder u_straps (
        .clk(CLK),
        .restart(restart),
        .pin_i(STRAP_I),
        .pin_o(STRAP_O),
        .pin_oe(STRAP_OE),
        .level(strap_level),
        .done(strap_done)
    );

    assign eq_strap = strap_level[2*retimer_power_pkg::STRAP_EQ +: 2];
    assign pre_strap = strap_level[2*retimer_power_pkg::STRAP_PRE +: 2];
    assign term_strap = strap_level[2*retimer_power_pkg::STRAP_TERM +: 2];
    assign redriver = control_reg[retimer_power_pkg::CTRL_REDRIVER_BIT];

    // Power state selection, highest priority first
    always_comb begin
        state_next = retimer_power_pkg::PS_NORMAL;
        if (!power_en) begin
            state_next = retimer_power_pkg::PS_OFF;
        end else if (control_reg[retimer_power_pkg::CTRL_SW_POWER_DOWN_BIT]) begin
            state_next = retimer_power_pkg::PS_POWER_DOWN;
        end else if (!sink_hpd) begin
            state_next = retimer_power_pkg::PS_POWER_DOWN;
        end else if (!clock_valid && (!redriver || sig_det_en)) begin
            state_next = retimer_power_pkg::PS_STANDBY;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg <= retimer_power_pkg::PS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lane, port and output enables, registered from the current state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            LINK_DATA_INPUTS_ENABLE <= 3'h0;
            INPUT_CLOCK_ENABLE <= 1'b0;
            LINK_DATA_OUTPUTS_ENABLE <= 1'b0;
            CDR_ENABLE <= 1'b0;
            DDC_ENABLE <= 1'b0;
            ARC_ENABLE <= 1'b0;
            CONTROL_SERIAL_PORT_ENABLE <= 1'b0;
        end else begin
            case (state_reg)
                retimer_power_pkg::PS_OFF: begin
                    LINK_DATA_INPUTS_ENABLE <= 3'h0;
                    INPUT_CLOCK_ENABLE <= 1'b0;
                    LINK_DATA_OUTPUTS_ENABLE <= 1'b0;
                    CDR_ENABLE <= 1'b0;
                    DDC_ENABLE <= 1'b0;
                    ARC_ENABLE <= 1'b0;
                    CONTROL_SERIAL_PORT_ENABLE <= 1'b0;
                end
                retimer_power_pkg::PS_POWER_DOWN: begin
                    LINK_DATA_INPUTS_ENABLE <= 3'h0;
                    INPUT_CLOCK_ENABLE <= 1'b0;
                    LINK_DATA_OUTPUTS_ENABLE <= 1'b0;
                    CDR_ENABLE <= 1'b0;
                    DDC_ENABLE <= 1'b0;
                    ARC_ENABLE <= 1'b0;
                    CONTROL_SERIAL_PORT_ENABLE <= 1'b1;
                end
                retimer_power_pkg::PS_STANDBY: begin
                    LINK_DATA_INPUTS_ENABLE <= 3'h0;
                    INPUT_CLOCK_ENABLE <= 1'b1;
                    LINK_DATA_OUTPUTS_ENABLE <= 1'b0;
                    CDR_ENABLE <= 1'b0;
                    DDC_ENABLE <= 1'b1;
                    ARC_ENABLE <= 1'b1;
                    CONTROL_SERIAL_PORT_ENABLE <= 1'b1;
                end
                default: begin
                    LINK_DATA_INPUTS_ENABLE <= 3'h7;
                    INPUT_CLOCK_ENABLE <= 1'b1;
                    LINK_DATA_OUTPUTS_ENABLE <= 1'b1;
                    CDR_ENABLE <= !redriver;
                    DDC_ENABLE <= 1'b1;
                    ARC_ENABLE <= 1'b1;
                    CONTROL_SERIAL_PORT_ENABLE <= 1'b1;
                end
            endcase
        end
    end

    // Termination stays on in every state, including unpowered
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RX_TERMINATION_ON <= 1'b1;
        end else begin
            RX_TERMINATION_ON <= 1'b1;
        end
    end

    // Source hot-plug follows the sink input in all states
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SOURCE_HOTPLUG_OUT <= 1'b0;
        end else begin
            SOURCE_HOTPLUG_OUT <= sink_hpd;
        end
    end

    // Power state flags for software
    always_ff @(posedge CLK) begin
        if (RESET) begin
            POWER_DOWN_FLAG <= 1'b0;
            STANDBY_FLAG <= 1'b0;
        end else begin
            POWER_DOWN_FLAG <= (state_reg == retimer_power_pkg::PS_POWER_DOWN)
                || (state_reg == retimer_power_pkg::PS_OFF);
            STANDBY_FLAG <= (state_reg == retimer_power_pkg::PS_STANDBY);
        end
    end

    // Bus decode: one aligned word per register
    assign word_aligned = (AVS_ADDRESS[1:0] == 2'h0);
    assign sel_control = word_aligned && (AVS_ADDRESS[7:2] == retimer_power_pkg::REG_CONTROL_IDX);
    assign sel_eq_config = word_aligned && (AVS_ADDRESS[7:2] == retimer_power_pkg::REG_EQ_CONFIG_IDX);
    assign sel_status = word_aligned && (AVS_ADDRESS[7:2] == retimer_power_pkg::REG_STATUS_IDX);
    assign sel_strap = word_aligned && (AVS_ADDRESS[7:2] == retimer_power_pkg::REG_STRAP_IDX);

    // Request is taken on the edge where waitrequest is already low
    assign read_take = AVS_READ && !AVS_WAITREQUEST;
    assign write_take = AVS_WRITE && !AVS_WAITREQUEST;

    // Waitrequest drops for one cycle, one cycle after a request appears
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        read_value = 32'h00000000;
        if (sel_control) begin
            read_value[7:0] = control_reg;
        end else if (sel_eq_config) begin
            read_value[8:0] = eq_config_reg;
        end else if (sel_status) begin
            read_value[retimer_power_pkg::STATUS_POWER_DOWN_BIT] = POWER_DOWN_FLAG;
            read_value[retimer_power_pkg::STATUS_STANDBY_BIT] = STANDBY_FLAG;
        end else if (sel_strap) begin
            read_value[5:0] = strap_level;
            read_value[7] = strap_done;
        end
    end

    // Read data loaded while waitrequest is high, standing when it drops
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AVS_READDATA <= 32'h00000000;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            AVS_READDATA <= read_value;
        end
    end

    // Control register; writes only count while the port is powered
    always_ff @(posedge CLK) begin
        if (restart) begin
            control_reg <= retimer_power_pkg::CTRL_RESET;
        end else if (write_take && sel_control && power_en && AVS_BYTEENABLE[0]) begin
            control_reg <= AVS_WRITEDATA[7:0];
        end
    end

    // Equalizer and driver configuration register
    always_ff @(posedge CLK) begin
        if (restart) begin
            eq_config_reg <= retimer_power_pkg::EQCFG_RESET;
        end else if (write_take && sel_eq_config && power_en) begin
            if (AVS_BYTEENABLE[0]) begin
                eq_config_reg[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                eq_config_reg[8] <= AVS_WRITEDATA[8];
            end
        end
    end

    // Mode and lane swap outputs
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RETIMER_MODE <= 1'b1;
            LANE_SWAP <= 1'b0;
        end else begin
            RETIMER_MODE <= !redriver;
            LANE_SWAP <= control_reg[retimer_power_pkg::CTRL_LANE_SWAP_BIT];
        end
    end

    // Analog settings from the override register or else from straps
    always_ff @(posedge CLK) begin
        if (RESET) begin
            EQ_ADAPTIVE <= 1'b1;
            EQ_FIXED_LEVEL <= 2'h0;
            PREEMPHASIS_LEVEL <= 2'h0;
            TX_TERMINATION_SEL <= 2'h0;
        end else if (eq_config_reg[retimer_power_pkg::EQCFG_OVERRIDE_BIT]) begin
            EQ_ADAPTIVE <= !eq_config_reg[retimer_power_pkg::EQCFG_FIXED_BIT];
            EQ_FIXED_LEVEL <= eq_config_reg[retimer_power_pkg::EQCFG_LEVEL_LSB +: 2];
            PREEMPHASIS_LEVEL <= eq_config_reg[retimer_power_pkg::EQCFG_PRE_LSB +: 2];
            TX_TERMINATION_SEL <= eq_config_reg[retimer_power_pkg::EQCFG_TERM_LSB +: 2];
        end else begin
            EQ_ADAPTIVE <= (eq_strap == retimer_power_pkg::STRAP_MID);
            EQ_FIXED_LEVEL <= eq_strap;
            PREEMPHASIS_LEVEL <= pre_strap;
            TX_TERMINATION_SEL <= term_strap;
        end
    end
endmodule : retimer_power_state_control

// ---- retimer_power_pkg.sv ----
/*
 Shared constants and types for the retimer power-state controller:
 register indices, field positions, reset values, timing counts and strap codes.
 Assumes a 200 MHz system clock.
*/
package retimer_power_pkg;
    // System clock
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Input clock lane must rise within this time to stay valid
    localparam int unsigned CLOCK_LOSS_TIME_NS = 200;
    localparam int unsigned CLOCK_LOSS_CYCLES = (CLOCK_LOSS_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CLOCK_VALID_EDGES = 4;
    // Settling time per strap probe phase, rounded up
    localparam int unsigned STRAP_SETTLE_TIME_NS = 100;
    localparam int unsigned STRAP_SETTLE_CYCLES =
        (STRAP_SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register indices; byte address is four times the index
    localparam logic [5:0] REG_CONTROL_IDX = 6'h09;
    localparam logic [5:0] REG_EQ_CONFIG_IDX = 6'h0a;
    localparam logic [5:0] REG_STATUS_IDX = 6'h20;
    localparam logic [5:0] REG_STRAP_IDX = 6'h21;

    // Control register fields
    localparam int unsigned CTRL_LANE_SWAP_BIT = 0;
    localparam int unsigned CTRL_REDRIVER_BIT = 1;
    localparam int unsigned CTRL_SW_POWER_DOWN_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Equalizer and driver configuration fields
    localparam int unsigned EQCFG_LEVEL_LSB = 0;
    localparam int unsigned EQCFG_FIXED_BIT = 2;
    localparam int unsigned EQCFG_PRE_LSB = 4;
    localparam int unsigned EQCFG_TERM_LSB = 6;
    localparam int unsigned EQCFG_OVERRIDE_BIT = 8;
    localparam logic [8:0] EQCFG_RESET = 9'h000;

    // Status register fields
    localparam int unsigned STATUS_POWER_DOWN_BIT = 7;
    localparam int unsigned STATUS_STANDBY_BIT = 6;

    // Tri-level strap codes
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_MID = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    localparam int unsigned NUM_STRAPS = 3;
    localparam int unsigned STRAP_EQ = 0;
    localparam int unsigned STRAP_PRE = 1;
    localparam int unsigned STRAP_TERM = 2;

    // Synchronised pin vector positions
    localparam int unsigned PIN_POWER_ENABLE = 0;
    localparam int unsigned PIN_SINK_HOTPLUG = 1;
    localparam int unsigned PIN_SIGNAL_DETECT_EN = 2;
    localparam int unsigned NUM_PINS = 3;

    typedef enum logic [1:0] {PS_OFF, PS_POWER_DOWN, PS_STANDBY, PS_NORMAL} power_state_t;
    typedef enum logic [1:0] {SP_DRIVE_HIGH, SP_DRIVE_LOW, SP_DONE} strap_phase_t;
endpackage : retimer_power_pkg

// ---- clock_presence_detector.sv ----
/*
 Detects a valid clock on the input clock lane by sampling it on the system clock.
 Assumes the lane is asynchronous and slower than a quarter of the system clock.
*/
`timescale 1ns/1ps
module clock_presence_detector (
    input wire logic clk,
    input wire logic reset,
    input wire logic lane_in,
    output logic valid
);
    logic s1_reg, s2_reg, s3_reg;
    logic level_reg;
    logic [7:0] quiet_reg;
    logic [2:0] edges_reg;
    logic rise;

    // Three-stage sampler; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= lane_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign rise = (s2_reg == s3_reg) && s3_reg && !level_reg;

    // Edge counting with a loss timeout
    always_ff @(posedge clk) begin
        if (reset) begin
            quiet_reg <= 8'h00;
            edges_reg <= 3'h0;
            valid <= 1'b0;
        end else if (rise) begin
            quiet_reg <= 8'h00;
            if (edges_reg < 3'(retimer_power_pkg::CLOCK_VALID_EDGES - 1)) begin
                edges_reg <= edges_reg + 3'h1;
            end else begin
                valid <= 1'b1;
            end
        end else if (quiet_reg >= 8'(retimer_power_pkg::CLOCK_LOSS_CYCLES - 1)) begin
            edges_reg <= 3'h0;
            valid <= 1'b0;
        end else begin
            quiet_reg <= quiet_reg + 8'h01;
        end
    end
endmodule : clock_presence_detector

// ---- strap_tri_level_decoder.sv ----
/*
 Decodes tri-level strap pins by driving each high, then low, and reading back.
 Assumes the board pulls a strapped pin harder than the probe drive; a floating pin follows.
*/
`timescale 1ns/1ps
module strap_tri_level_decoder (
    input wire logic clk,
    input wire logic restart,
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe,
    output logic [5:0] level,
    output logic done
);
    retimer_power_pkg::strap_phase_t phase_reg;
    logic [4:0] count_reg;
    logic [2:0] high_seen_reg;
    logic [2:0] s1_reg, s2_reg, s3_reg;
    logic settled;

    // Three-stage sampler per pin
    always_ff @(posedge clk) begin
        s1_reg <= pin_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    assign settled = (count_reg == 5'(retimer_power_pkg::STRAP_SETTLE_CYCLES - 1)) && (s2_reg == s3_reg);

    // Probe sequence, rerun on every restart
    always_ff @(posedge clk) begin
        if (restart) begin
            phase_reg <= retimer_power_pkg::SP_DRIVE_HIGH;
            count_reg <= 5'h00;
            high_seen_reg <= 3'h0;
            pin_o <= 3'h7;
            pin_oe <= 3'h7;
            done <= 1'b0;
        end else begin
            case (phase_reg)
                retimer_power_pkg::SP_DRIVE_HIGH: begin
                    if (settled) begin
                        high_seen_reg <= s3_reg;
                        pin_o <= 3'h0;
                        count_reg <= 5'h00;
                        phase_reg <= retimer_power_pkg::SP_DRIVE_LOW;
                    end else if (count_reg != 5'(retimer_power_pkg::STRAP_SETTLE_CYCLES - 1)) begin
                        count_reg <= count_reg + 5'h01;
                    end
                end
                retimer_power_pkg::SP_DRIVE_LOW: begin
                    if (settled) begin
                        pin_oe <= 3'h0;
                        done <= 1'b1;
                        phase_reg <= retimer_power_pkg::SP_DONE;
                    end else if (count_reg != 5'(retimer_power_pkg::STRAP_SETTLE_CYCLES - 1)) begin
                        count_reg <= count_reg + 5'h01;
                    end
                end
                default: begin
                    pin_oe <= 3'h0;
                end
            endcase
        end
    end

    // Level per pin: held both ways, or followed the probe when floating
    for (genvar i = 0; i < 3; i++) begin : g_level
        always_ff @(posedge clk) begin
            if (restart) begin
                level[2*i +: 2] <= retimer_power_pkg::STRAP_MID;
            end else if (phase_reg == retimer_power_pkg::SP_DRIVE_LOW && settled) begin
                if (high_seen_reg[i] && s3_reg[i]) begin
                    level[2*i +: 2] <= retimer_power_pkg::STRAP_HIGH;
                end else if (!high_seen_reg[i] && !s3_reg[i]) begin
                    level[2*i +: 2] <= retimer_power_pkg::STRAP_LOW;
                end else begin
                    level[2*i +: 2] <= retimer_power_pkg::STRAP_MID;
                end
            end
        end
    end
endmodule : strap_tri_level_decoder

// ---- retimer_power_props.sv ----
/*
 Port checker for the retimer power-state controller.
 Assumes it is bound onto the controller's top module.
*/
`timescale 1ns/1ps
module retimer_power_props (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic POWER_ENABLE,
    input wire logic SINK_HOTPLUG_IN,
    input wire logic SOURCE_HOTPLUG_OUT,
    input wire logic [2:0] LINK_DATA_INPUTS_ENABLE,
    input wire logic INPUT_CLOCK_ENABLE,
    input wire logic RX_TERMINATION_ON,
    input wire logic LINK_DATA_OUTPUTS_ENABLE,
    input wire logic DDC_ENABLE,
    input wire logic ARC_ENABLE,
    input wire logic CONTROL_SERIAL_PORT_ENABLE,
    input wire logic POWER_DOWN_FLAG,
    input wire logic STANDBY_FLAG,
    input wire logic CONFIG_RESET
);
    // Enables packed: port, DDC, ARC, clock in, outputs, D2..D0
    wire logic [7:0] en = {CONTROL_SERIAL_PORT_ENABLE, DDC_ENABLE, ARC_ENABLE, INPUT_CLOCK_ENABLE,
        LINK_DATA_OUTPUTS_ENABLE, LINK_DATA_INPUTS_ENABLE};
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Released for one cycle, then waitrequest high again
    sequence s_ack;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    sequence s_off;
        !POWER_ENABLE [*8];
    endsequence
    chk_bus_answer: assert property ($rose(AVS_READ || AVS_WRITE) |-> ##1 s_ack)
        else $error("bus answer not one cycle");
    chk_term_on: assert property (RX_TERMINATION_ON)
        else $error("termination dropped");
    chk_off_quiet: assert property (s_off |-> en == 8'h00 && POWER_DOWN_FLAG)
        else $error("unpowered block active");
    chk_pd_port: assert property ((POWER_ENABLE && !SINK_HOTPLUG_IN) [*8] |-> en == 8'h80)
        else $error("hotplug low not power-down");
    chk_hpd_mirror: assert property ($stable(SINK_HOTPLUG_IN) [*8] |-> SOURCE_HOTPLUG_OUT == SINK_HOTPLUG_IN)
        else $error("source hotplug differs");
    chk_standby_lanes: assert property (STANDBY_FLAG |-> en == 8'hf0)
        else $error("standby enables wrong");
    chk_cfg_pulse: assert property ($rose(POWER_ENABLE) |-> ##[1:8] CONFIG_RESET)
        else $error("no reset on power rise");
    chk_pulse_once: assert property (CONFIG_RESET |=> !CONFIG_RESET)
        else $error("config reset too long");
endmodule : retimer_power_props
bind retimer_power_state_control retimer_power_props u_props (.*);

// ---- link_source_model.sv ----
/*
 Far side: clock lane source and strap resistors.
 Assumes a strap resistor beats the probe drive.
*/
`timescale 1ns/1ps
module link_source_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [5:0] straps,
    input wire logic [2:0] strap_o,
    input wire logic [2:0] strap_oe,
    output logic lane,
    output logic [2:0] strap_i
);
    logic alt = 1'b0;
    // Lane clock of 48 ns, still when stopped
    initial lane = 1'b0;
    always #24 lane = run & ~lane;
    always @(posedge clk) alt <= ~alt;
    // Pulled pin wins; open pin follows drive or wanders
    always_comb for (int i = 0; i < 3; i++) strap_i[i] = straps[2*i+:2] == 2'h0 ? 1'b0 :
        straps[2*i+:2] == 2'h2 ? 1'b1 : strap_oe[i] ? strap_o[i] : alt;
endmodule : link_source_model

// ---- retimer_power_state_control_bench.sv ----
/*
 Bench for the retimer power-state controller.
 Assumes the bound checker and the source model.
*/
`timescale 1ns/1ps
module retimer_power_state_control_bench;
    logic RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, POWER_ENABLE, SINK_HOTPLUG_IN, SIGNAL_DETECT_ENABLE;
    logic INPUT_CLOCK_LANE, SOURCE_HOTPLUG_OUT, INPUT_CLOCK_ENABLE, RX_TERMINATION_ON, LINK_DATA_OUTPUTS_ENABLE;
    logic CDR_ENABLE, DDC_ENABLE, ARC_ENABLE, CONTROL_SERIAL_PORT_ENABLE, RETIMER_MODE, LANE_SWAP, EQ_ADAPTIVE;
    logic CLK = 1'b0, POWER_DOWN_FLAG, STANDBY_FLAG, CONFIG_RESET, run, sw, rt;
    logic [1:0] EQ_FIXED_LEVEL, PREEMPHASIS_LEVEL, TX_TERMINATION_SEL;
    logic [2:0] STRAP_I, STRAP_O, STRAP_OE, LINK_DATA_INPUTS_ENABLE;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [5:0] straps;
    logic [7:0] AVS_ADDRESS, e;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
    int fails, n_checks;
    retimer_power_state_control u_retimer_power_state_control (.*);
    link_source_model u_link_source_model (.clk(CLK), .run(run), .straps(straps), .strap_o(STRAP_O),
        .strap_oe(STRAP_OE), .lane(INPUT_CLOCK_LANE), .strap_i(STRAP_I));
    initial forever #2.5 CLK = ~CLK;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task complete_run;
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // Bus access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 50);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        if (AVS_WAITREQUEST !== 1'b0) begin
            fails++;
            complete_run;
        end
    endtask : bus
    // Enables: port, DDC, ARC, clock in, outputs, D2..D0
    function automatic logic [7:0] exp_en(input logic pe, hp, ck, sd);
        if (!pe) return 8'h00;
        if (sw || !hp) return 8'h80;
        if (!ck && (rt || sd)) return 8'hf0;
        return 8'hff;
    endfunction : exp_en
    task automatic step(input logic pe, hp, ck, sd);
        @(posedge CLK);
        POWER_ENABLE <= pe;
        SINK_HOTPLUG_IN <= hp;
        SIGNAL_DETECT_ENABLE <= sd;
        run <= ck;
        repeat (80) @(posedge CLK);
        e = exp_en(pe, hp, ck, sd);
        chk("enables", {CONTROL_SERIAL_PORT_ENABLE, DDC_ENABLE, ARC_ENABLE, INPUT_CLOCK_ENABLE,
            LINK_DATA_OUTPUTS_ENABLE, LINK_DATA_INPUTS_ENABLE}, e);
        chk("flags", {POWER_DOWN_FLAG, STANDBY_FLAG}, {e < 8'hf0, e == 8'hf0});
        chk("hotplug", SOURCE_HOTPLUG_OUT, hp);
        chk("cdr", CDR_ENABLE, e == 8'hff && rt);
    endtask : step
    initial begin
        RESET = 1'b1;
        {AVS_READ, AVS_WRITE, POWER_ENABLE, SINK_HOTPLUG_IN, SIGNAL_DETECT_ENABLE, run, sw, rt} = 8'h01;
        {AVS_ADDRESS, AVS_WRITEDATA, fails, n_checks} = '0;
        void'($urandom(32'h165f4b91));
        straps = {2'($urandom_range(2)), 2'($urandom_range(2)), 2'($urandom_range(2))};
        repeat (3) @(posedge CLK);
        RESET <= 1'b0;
        chk("defaults", {RETIMER_MODE, RX_TERMINATION_ON}, 2'h3);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        bus(1'b0, 8'h84, 32'h0);
        chk("straps", q, {2'h2, straps});
        chk("eq adaptive", EQ_ADAPTIVE, straps[1:0] == 2'h1);
        chk("drive", {TX_TERMINATION_SEL, PREEMPHASIS_LEVEL, EQ_FIXED_LEVEL}, straps);
        bus(1'b0, 8'h80, 32'h0);
        chk("status", q, 32'h80);
        step(1'b1, 1'b1, 1'b0, 1'b0);
        bus(1'b0, 8'h80, 32'h0);
        chk("status", q, 32'h40);
        step(1'b1, 1'b1, 1'b1, 1'b1);
        bus(1'b1, 8'h24, 32'h8);
        bus(1'b1, 8'h28, 32'h1e5);
        sw = 1'b1;
        step(1'b1, 1'b1, 1'b1, 1'b1);
        chk("override", {EQ_ADAPTIVE, TX_TERMINATION_SEL, PREEMPHASIS_LEVEL, EQ_FIXED_LEVEL}, 7'h39);
        bus(1'b1, 8'h24, 32'h3);
        {sw, rt} = 2'h0;
        step(1'b1, 1'b1, 1'b0, 1'b0);
        chk("mode", {LANE_SWAP, RETIMER_MODE}, 2'h2);
        step(1'b1, 1'b1, 1'b0, 1'b1);
        bus(1'b0, 8'h0c, 32'h0);
        chk("unmapped", q, 32'h0);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        bus(1'b1, 8'h24, 32'h8);
        rt = 1'b1;
        step(1'b1, 1'b1, 1'b1, 1'b0);
        bus(1'b0, 8'h24, 32'h0);
        chk("control", q, 32'h0);
        chk("restored", {TX_TERMINATION_SEL, PREEMPHASIS_LEVEL, EQ_FIXED_LEVEL}, straps);
        complete_run;
    end
endmodule : retimer_power_state_control_bench
